/* hw/hsd_ctrl.sv */
// sdram host controller: access, precharge, refresh and power states
`timescale 1ns/1ps
// Behaviour
// [R01] single-write mode: every write is one column
// [R02] reads always follow programmed burst length
// [R03] A10 high precharges all, else bank
// [R04] activate a bank before read or write
// [R05] wait tRP after precharge before activate
// [R06] A10 on access auto precharges that access
// [R07] no auto precharge for page bursts
// [R08] after auto precharge wait tRP on bank
// [R09] read cuts auto precharge read after CL
// [R10] mask data ahead of write after read
// [R11] read cuts auto precharge write, tWR
// [R12] write cuts auto precharge write, tWR
// [R13] precharge all and wait tRP before refresh
// [R14] only NOPs for tRFC after refresh
// [R15] refresh every row within refresh period
// [R16] self refresh: refresh with clock enable low
// [R17] stay in self refresh at least tRAS
// [R18] NOPs for tXSR after raising clock enable
// [R19] resume distributed refresh after self refresh
// [R20] clock enable low with NOP: power-down
// [R21] leave power-down within refresh period
// [R22] clock enable low in burst suspends it
// [R23] device tracks each bank state separately
module hsd_ctrl import hsd_pkg::*; #(
	parameter int PD_MAX_CYC = PD_MAX_CYC_DEF
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// access requests
	input wire logic reqValid,
	input wire hsd_req_t req,
	output logic reqReady,
	// write and read data
	input wire logic [31:0] wrData,
	output logic wrTake,
	output logic [31:0] rdData,
	output logic rdValid,
	// configuration and power control
	input wire hsd_cfg_t cfg,
	input wire logic cfgLoad,
	input wire logic srReq,
	input wire logic pdReq,
	output logic inSelfRefresh,
	output logic inPowerDown,
	// memory pins
	output hsd_pins_t pins,
	output logic [31:0] dqOut,
	output logic dqOe,
	input wire logic [31:0] dqIn
);

	typedef enum {S_INIT, S_IDLE, S_PREALL, S_ACT, S_RW, S_BURST, S_PAGEPRE, S_WAIT, S_SRHOLD, S_SRXIT,
		S_PDOWN} hsd_state_t;
	typedef enum {P_MODE, P_REF, P_SELF} hsd_purpose_t;
	localparam int PDW = $clog2(PD_MAX_CYC + 1);

	hsd_state_t state, retState;
	hsd_purpose_t purpose;
	hsd_req_t cur;
	hsd_cfg_t cfgReg;
	logic [7:0] waitCnt;
	logic [8:0] beatCnt;
	logic [3:0] rowOpen;
	logic [11:0] openRow [4];
	logic [3:0] tmrLoad, tmrBusy;
	logic [7:0] tmrVal;
	logic [9:0] refCnt;
	logic refDue, refDone, refKick, cfgPend, rdBeat, drainRead;
	logic [7:0] rdShift;
	logic [PDW-1:0] pdCnt;

	// beats of one burst at a given length code
	function automatic logic [8:0] hsd_beats(input logic [2:0] code);
		case (code)
			3'h0: hsd_beats = 9'h001;
			3'h1: hsd_beats = 9'h002;
			3'h2: hsd_beats = 9'h004;
			3'h3: hsd_beats = 9'h008;
			BL_PAGE: hsd_beats = 9'(PAGE_BEATS);
			default: hsd_beats = 9'h001;
		endcase
	endfunction : hsd_beats

	// mode word carrying burst length, latency and write burst mode
	function automatic logic [11:0] hsd_mode(input hsd_cfg_t c);
		logic [11:0] m;
		m = 12'h000;
		m[MR_BL_LSB +: 3] = c.burstLen;
		m[MR_CL_LSB +: 3] = c.casLat;
		m[MR_WBM_BIT] = c.writeBurstModeBit;
		hsd_mode = m;
	endfunction : hsd_mode

	// ----------------------------------------
	// bank recovery timers
	// ----------------------------------------
	for (genvar b = 0; b < 4; b++) begin : g_bank
		hsd_bank_timer #(.W(8)) u_timer (
			.clk(clk),
			.rst_n(rst_n),
			.load(tmrLoad[b]),
			.loadVal(tmrVal),
			.busy(tmrBusy[b])
		);
	end

	// ----------------------------------------
	// refresh interval
	// ----------------------------------------
	// a due refresh wins over the clear issued with the previous one
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			refCnt <= 10'(REFI_CYC - 1);
			refDue <= 1'b0;
		end else if (refKick) begin
			refCnt <= 10'(REFI_CYC - 1); // R19
			refDue <= 1'b1;
		end else if (refCnt == 10'h000) begin
			refCnt <= 10'(REFI_CYC - 1); // R15
			refDue <= 1'b1;
		end else begin
			refCnt <= refCnt - 10'h001;
			if (refDone) begin
				refDue <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// read data capture
	// ----------------------------------------
	// beats travel down the shift line and are caught cas latency later
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdShift <= 8'h00;
			rdValid <= 1'b0;
			rdData <= 32'h0000_0000;
		end else begin
			rdShift <= {rdShift[6:0], rdBeat};
			rdValid <= rdShift[3'(cfgReg.casLat - 3'h1)];
			if (rdShift[3'(cfgReg.casLat - 3'h1)]) begin
				rdData <= dqIn;
			end
		end
	end

	// ----------------------------------------
	// command sequencer
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= S_INIT;
			retState <= S_IDLE;
			purpose <= P_MODE;
			cur <= '0;
			cfgReg <= CFG_RESET;
			waitCnt <= 8'h00;
			beatCnt <= 9'h000;
			rowOpen <= 4'h0;
			openRow <= '{default: 12'h000};
			tmrLoad <= 4'h0;
			tmrVal <= 8'h00;
			refDone <= 1'b0;
			refKick <= 1'b0;
			cfgPend <= 1'b0;
			rdBeat <= 1'b0;
			drainRead <= 1'b0;
			pdCnt <= '0;
			reqReady <= 1'b0;
			wrTake <= 1'b0;
			inSelfRefresh <= 1'b0;
			inPowerDown <= 1'b0;
			pins <= PINS_RESET;
			dqOut <= 32'h0000_0000;
			dqOe <= 1'b0;
		end else begin
			// defaults: NOP, data masked, bus released
			pins.csN <= 1'b0;
			pins.cmd <= CMD_NOP;
			pins.dqm <= 1'b1; // R10
			dqOe <= 1'b0;
			wrTake <= 1'b0;
			rdBeat <= 1'b0;
			tmrLoad <= 4'h0;
			refDone <= 1'b0;
			refKick <= 1'b0;
			reqReady <= 1'b0;
			if (cfgLoad) begin
				cfgPend <= 1'b1;
			end
			case (state)
				S_INIT: begin
					purpose <= P_MODE;
					state <= S_PREALL;
				end
				S_IDLE: begin
					if (refDue) begin
						purpose <= P_REF;
						state <= S_PREALL;
					end else if (srReq) begin
						purpose <= P_SELF;
						state <= S_PREALL;
					end else if (cfgPend) begin
						purpose <= P_MODE;
						state <= S_PREALL;
					end else if (pdReq) begin
						pins.cke <= 1'b0;
						pdCnt <= '0;
						inPowerDown <= 1'b1;
						state <= S_PDOWN;
					end else if (reqValid) begin
						cur <= req;
						reqReady <= 1'b1;
						state <= S_ACT;
					end
				end
				S_PREALL: begin
					if (|rowOpen) begin
						pins.cmd <= CMD_PRE;
						pins.addr <= 12'h000;
						pins.addr[ADDR_AP_BIT] <= 1'b1; // R03
						rowOpen <= 4'h0;
						tmrLoad <= 4'hf;
						tmrVal <= 8'(RP_CYC);
					end else if (tmrBusy == 4'h0) begin // R13
						pins.addr <= 12'h000;
						pins.ba <= 2'h0;
						case (purpose)
							P_MODE: begin
								pins.cmd <= CMD_MRS;
								pins.addr <= hsd_mode(cfg);
								cfgReg <= cfg;
								cfgPend <= cfgLoad;
								waitCnt <= 8'(T_MRD_CLK - 1);
								retState <= S_IDLE;
								state <= S_WAIT;
							end
							P_REF: begin
								pins.cmd <= CMD_REF;
								refDone <= 1'b1;
								waitCnt <= 8'(RFC_CYC - 1); // R14
								retState <= S_IDLE;
								state <= S_WAIT;
							end
							default: begin
								pins.cmd <= CMD_REF;
								pins.cke <= 1'b0; // R16
								inSelfRefresh <= 1'b1;
								waitCnt <= 8'(RAS_CYC); // R17
								state <= S_SRHOLD;
							end
						endcase
					end
				end
				S_ACT: begin
					if (rowOpen[cur.bank] && openRow[cur.bank] == cur.row) begin
						state <= S_RW;
					end else if (rowOpen[cur.bank]) begin
						pins.cmd <= CMD_PRE;
						pins.ba <= cur.bank;
						pins.addr <= 12'h000; // R03
						rowOpen[cur.bank] <= 1'b0;
						tmrLoad[cur.bank] <= 1'b1;
						tmrVal <= 8'(RP_CYC);
					end else if (!tmrBusy[cur.bank]) begin // R05
						pins.cmd <= CMD_ACT;
						pins.ba <= cur.bank;
						pins.addr <= cur.row;
						rowOpen[cur.bank] <= 1'b1; // R04
						openRow[cur.bank] <= cur.row;
						waitCnt <= 8'(RCD_CYC - 1);
						retState <= S_RW;
						state <= S_WAIT;
					end
				end
				S_RW: begin
					pins.cmd <= cur.write ? CMD_WRITE : CMD_READ;
					pins.ba <= cur.bank;
					pins.addr <= {4'h0, cur.col};
					pins.addr[ADDR_AP_BIT] <= cur.autoPre && cfgReg.burstLen != BL_PAGE; // R06 R07
					pins.dqm <= 1'b0;
					if (cur.write) begin
						beatCnt <= cfgReg.writeBurstModeBit ? 9'h000 : hsd_beats(cfgReg.burstLen) - 9'h001; // R01
						dqOut <= wrData;
						dqOe <= 1'b1;
						wrTake <= 1'b1;
					end else begin
						beatCnt <= hsd_beats(cfgReg.burstLen) - 9'h001; // R02
						rdBeat <= 1'b1;
					end
					state <= S_BURST;
				end
				S_BURST: begin
					if (beatCnt != 9'h000) begin
						beatCnt <= beatCnt - 9'h001;
						pins.dqm <= 1'b0;
						if (cur.write) begin
							dqOut <= wrData;
							dqOe <= 1'b1;
							wrTake <= 1'b1;
						end else begin
							rdBeat <= 1'b1;
						end
					end else begin
						if (cur.autoPre && cfgReg.burstLen != BL_PAGE) begin
							rowOpen[cur.bank] <= 1'b0; // R06
							tmrLoad[cur.bank] <= 1'b1; // R08
							tmrVal <= cur.write ? 8'(WR_CYC + RP_CYC) : 8'(RP_CYC);
						end
						drainRead <= !cur.write;
						pins.dqm <= cur.write;
						waitCnt <= cur.write ? 8'(WR_CYC - 1) : 8'({5'h00, cfgReg.casLat});
						retState <= (cfgReg.burstLen == BL_PAGE) ? S_PAGEPRE : S_IDLE; // R07
						state <= S_WAIT;
					end
				end
				S_PAGEPRE: begin
					pins.cmd <= CMD_PRE;
					pins.ba <= cur.bank;
					pins.addr <= 12'h000;
					rowOpen[cur.bank] <= 1'b0;
					tmrLoad[cur.bank] <= 1'b1;
					tmrVal <= 8'(RP_CYC);
					state <= S_IDLE;
				end
				S_WAIT: begin
					pins.dqm <= !drainRead; // R10
					if (waitCnt == 8'h00) begin
						drainRead <= 1'b0;
						state <= retState;
					end else begin
						waitCnt <= waitCnt - 8'h01;
					end
				end
				S_SRHOLD: begin
					if (waitCnt != 8'h00) begin
						waitCnt <= waitCnt - 8'h01;
					end else if (!srReq) begin
						pins.cke <= 1'b1;
						inSelfRefresh <= 1'b0;
						waitCnt <= 8'(T_XSR_CLK - 1); // R18
						state <= S_SRXIT;
					end
				end
				S_SRXIT: begin
					if (waitCnt == 8'h00) begin
						refKick <= 1'b1; // R19
						state <= S_IDLE;
					end else begin
						waitCnt <= waitCnt - 8'h01;
					end
				end
				S_PDOWN: begin
					pdCnt <= pdCnt + 1'b1;
					if (!pdReq || refDue || pdCnt == PDW'(PD_MAX_CYC - 1)) begin // R21
						pins.cke <= 1'b1;
						inPowerDown <= 1'b0;
						state <= S_IDLE;
					end
				end
				default: state <= S_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	access_needs_row_a: assert property (@(posedge clk) disable iff (!rst_n) // R04
		(pins.cmd == CMD_READ || pins.cmd == CMD_WRITE) |-> rowOpen[pins.ba])
		else $error("access to a bank without an open row");
	refresh_all_idle_a: assert property (@(posedge clk) disable iff (!rst_n) // R13
		(pins.cmd == CMD_REF) |-> rowOpen == 4'h0 && $past(pins.cmd) != CMD_PRE)
		else $error("refresh with an open row or too soon after precharge");
	refresh_nop_gap_a: assert property (@(posedge clk) disable iff (!rst_n) // R14
		(pins.cmd == CMD_REF && pins.cke) |=> (pins.cmd == CMD_NOP)[*2])
		else $error("command inside refresh cycle time");
	self_hold_low_a: assert property (@(posedge clk) disable iff (!rst_n) // R16
		inSelfRefresh |-> !pins.cke)
		else $error("clock enable high during self refresh");
	self_min_stay_a: assert property (@(posedge clk) disable iff (!rst_n) // R17
		(pins.cmd == CMD_REF && !pins.cke) |=> (!pins.cke)[*2])
		else $error("self refresh left before minimum time");
	exit_nop_pair_a: assert property (@(posedge clk) disable iff (!rst_n) // R18
		$rose(pins.cke) |-> pins.cmd == CMD_NOP ##1 pins.cmd == CMD_NOP)
		else $error("command too soon after clock enable rose");
	resume_refresh_a: assert property (@(posedge clk) disable iff (!rst_n) // R19
		$fell(inSelfRefresh) |-> ##[1:4] refDue)
		else $error("no refresh after self refresh exit");
	pd_time_bound_a: assert property (@(posedge clk) disable iff (!rst_n) // R21
		inPowerDown |-> pdCnt < PDW'(PD_MAX_CYC))
		else $error("power-down held too long");
	write_no_contend_a: assert property (@(posedge clk) disable iff (!rst_n) // R10
		(pins.cmd == CMD_WRITE) |-> rdShift[2:0] == 3'h0 && !rdBeat)
		else $error("write issued with read data in flight");

endmodule : hsd_ctrl

/* hw/hsd_pkg.sv */
// shared constants, encodings and carrier types of the sdram host controller
package hsd_pkg;

	// ----------------------------------------
	// clock and timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 40;
	localparam int T_RP_NS = 20;
	localparam int T_RCD_NS = 20;
	localparam int T_RFC_NS = 66;
	localparam int T_RAS_NS = 42;
	localparam int T_WR_NS = 12;
	localparam int T_MRD_CLK = 2;
	localparam int T_XSR_CLK = 2;
	localparam int T_REF_MS = 64;
	localparam int REF_ROWS = 4096;
	localparam int T_PD_MAX_MS = 64;
	// least times round up, longest times round down
	localparam int RP_CYC = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RCD_CYC = (T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RFC_CYC = (T_RFC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RAS_CYC = (T_RAS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WR_CYC = (T_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REFI_CYC = (T_REF_MS * 1000000 / REF_ROWS) / CLK_PERIOD_NS;
	localparam int PD_MAX_CYC_DEF = T_PD_MAX_MS * 1000000 / CLK_PERIOD_NS;

	// ----------------------------------------
	// command encodings {ras_n, cas_n, we_n}
	// ----------------------------------------
	localparam logic [2:0] CMD_MRS = 3'h0;
	localparam logic [2:0] CMD_REF = 3'h1;
	localparam logic [2:0] CMD_PRE = 3'h2;
	localparam logic [2:0] CMD_ACT = 3'h3;
	localparam logic [2:0] CMD_WRITE = 3'h4;
	localparam logic [2:0] CMD_READ = 3'h5;
	localparam logic [2:0] CMD_NOP = 3'h7;

	// ----------------------------------------
	// address and mode field layout
	// ----------------------------------------
	localparam int ADDR_AP_BIT = 10;
	localparam int MR_WBM_BIT = 9;
	localparam int MR_CL_LSB = 4;
	localparam int MR_BL_LSB = 0;
	localparam logic [2:0] BL_PAGE = 3'h7;
	localparam int PAGE_BEATS = 256;

	// ----------------------------------------
	// carrier types
	// ----------------------------------------
	typedef struct packed {
		logic cke;
		logic csN;
		logic [2:0] cmd;
		logic [1:0] ba;
		logic [11:0] addr;
		logic dqm;
	} hsd_pins_t;

	typedef struct packed {
		logic write;
		logic autoPre;
		logic [1:0] bank;
		logic [11:0] row;
		logic [7:0] col;
	} hsd_req_t;

	typedef struct packed {
		logic [2:0] burstLen;
		logic writeBurstModeBit;
		logic [2:0] casLat;
	} hsd_cfg_t;

	localparam hsd_pins_t PINS_RESET = '{cke: 1'b1, csN: 1'b1, cmd: CMD_NOP, ba: 2'h0, addr: 12'h000, dqm: 1'b1};
	localparam hsd_cfg_t CFG_RESET = '{burstLen: 3'h2, writeBurstModeBit: 1'b0, casLat: 3'h2};

endpackage : hsd_pkg

/* hw/hsd_bank_timer.sv */
// per-bank precharge recovery timer
`timescale 1ns/1ps
module hsd_bank_timer #(
	parameter int W = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// load request
	input wire logic load,
	input wire logic [W-1:0] loadVal,
	// bank may not be opened while high
	output logic busy
);

	logic [W-1:0] cnt;

	// ----------------------------------------
	// countdown
	// ----------------------------------------
	// count down the recovery interval after a precharge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= '0;
		end else if (load) begin
			cnt <= loadVal;
		end else if (cnt != '0) begin
			cnt <= cnt - 1'b1;
		end
	end

	// a pending load already counts as busy
	assign busy = load | (cnt != '0);

endmodule : hsd_bank_timer

/* dv/hsd_sdram_model.sv */
// behavioural sdram device model that answers the host controller pins
`timescale 1ns/1ps
module hsd_sdram_model import hsd_pkg::*; (
	// clock
	input wire logic clk,
	// controller pins
	input wire hsd_pins_t pins,
	input wire logic [31:0] dqOut,
	// read data towards the controller
	output logic [31:0] dqIn,
	// count of controller timing faults
	output int violCnt
);
	// ----------------------------------------
	// array, bank and burst state
	// ----------------------------------------
	logic [31:0] mem [int];
	logic [31:0] outQ [int];
	logic bankOpen [4] = '{default: 1'b0};
	logic [11:0] openRow [4];
	int readyAt [4] = '{default: 0};
	int cyc = 0, rdEnd = 0, rfcEnd = 0, xsrEnd = 0, bl = 4, cl = 2, wrLeft = 0;
	int srAt, n, wrI, b;
	logic [1:0] wrBank;
	logic [7:0] wrCol;
	logic wbm = 1'b0, ckeQ = 1'b1, inSr = 1'b0;
	logic acc;

	function automatic int key(input logic [1:0] ba, input logic [7:0] c, input int i);
		logic [7:0] m;
		m = (bl == PAGE_BEATS) ? 8'hff : 8'(bl - 1);
		return {ba, openRow[ba], (c & ~m) | (8'(c + i) & m)};
	endfunction : key

	// ----------------------------------------
	// command decode, one pass per rising edge
	// ----------------------------------------
	always @(posedge clk) begin
		cyc = cyc + 1;
		// the fault count starts clean on the first edge
		if (cyc == 1) violCnt = 0;
		b = pins.ba;
		// clock enable back high ends self refresh
		if (inSr && pins.cke) begin
			inSr = 1'b0;
			if (cyc - srAt < RAS_CYC) violCnt++;
			xsrEnd = cyc + T_XSR_CLK;
		end
		acc = ckeQ && pins.cke && !pins.csN && (pins.cmd == CMD_READ || pins.cmd == CMD_WRITE);
		// owed write beats; a suspended edge freezes the burst
		if (ckeQ && wrLeft > 0 && !acc) begin
			if (!pins.dqm) mem[key(wrBank, wrCol, wrI)] = dqOut;
			wrI++;
			wrLeft--;
		end
		// inputs are ignored while a low clock enable is registered
		if (ckeQ && !inSr && !pins.csN && pins.cmd != CMD_NOP) begin
			if (cyc < rfcEnd || cyc <= xsrEnd) violCnt++;
			case (pins.cmd)
				CMD_MRS: begin
					bl = (pins.addr[2:0] == BL_PAGE) ? PAGE_BEATS : 1 << pins.addr[2:0];
					cl = pins.addr[6:4];
					wbm = pins.addr[MR_WBM_BIT];
				end
				CMD_ACT: begin
					if (bankOpen[b] || cyc < readyAt[b]) violCnt++;
					bankOpen[b] = 1'b1;
					openRow[b] = pins.addr;
				end
				CMD_PRE: begin
					for (int k = 0; k < 4; k++) if (pins.addr[ADDR_AP_BIT] || k == b) begin
						bankOpen[k] = 1'b0;
						readyAt[k] = cyc + RP_CYC;
					end
				end
				CMD_REF: begin
					for (int k = 0; k < 4; k++) if (bankOpen[k] || cyc < readyAt[k]) violCnt++;
					rfcEnd = cyc + RFC_CYC;
					if (!pins.cke) begin
						inSr = 1'b1;
						srAt = cyc;
					end
				end
				default: begin
					if (!bankOpen[b]) violCnt++;
					// a new access cuts any running burst
					wrLeft = 0;
					if (pins.cmd == CMD_WRITE) rdEnd = cyc + 1;
					n = (pins.cmd == CMD_WRITE && wbm) ? 1 : bl;
					if (pins.cmd == CMD_READ) begin
						for (int i = 0; i < n; i++) begin
							outQ[cyc + cl + i] = mem.exists(key(b, pins.addr[7:0], i)) ?
								mem[key(b, pins.addr[7:0], i)] : ~key(b, pins.addr[7:0], i);
						end
						rdEnd = cyc + cl + n;
					end else begin
						wrBank = pins.ba;
						wrCol = pins.addr[7:0];
						if (!pins.dqm) mem[key(wrBank, wrCol, 0)] = dqOut;
						wrI = 1;
						wrLeft = n - 1;
					end
					// auto precharge, never for page bursts
					if (pins.addr[ADDR_AP_BIT] && bl != PAGE_BEATS) begin
						bankOpen[b] = 1'b0;
						readyAt[b] = cyc + ((pins.cmd == CMD_READ) ? bl + RP_CYC : n - 1 + WR_CYC + RP_CYC);
					end
				end
			endcase
		end
		ckeQ = pins.cke;
		// a released bus shows the inverse of its last value
		dqIn <= (outQ.exists(cyc + 1) && cyc + 1 < rdEnd) ? outQ[cyc + 1] : ((cyc == 1) ? 32'h0 : ~dqIn);
	end

endmodule : hsd_sdram_model

/* dv/hsd_ctrl_tb.sv */
// self-checking bench of the sdram host controller
`timescale 1ns/1ps
module hsd_ctrl_tb import hsd_pkg::*; ;
	// ----------------------------------------
	// signals and bookkeeping
	// ----------------------------------------
	logic clk, rst_n, reqValid, reqReady, wrTake, rdValid, cfgLoad, srReq, pdReq;
	logic inSelfRefresh, inPowerDown, dqOe;
	logic accA10 = 1'b0;
	hsd_req_t req;
	hsd_cfg_t cfg;
	hsd_pins_t pins;
	logic [31:0] wrData, rdData, dqOut, dqIn;
	logic [31:0] rdQ [$];
	int violCnt, errorCnt, nChecks, got, r0, k;
	int refCnt = 0;

	hsd_ctrl #(.PD_MAX_CYC(50)) dut (.clk(clk), .rst_n(rst_n), .reqValid(reqValid), .req(req),
		.reqReady(reqReady), .wrData(wrData), .wrTake(wrTake), .rdData(rdData), .rdValid(rdValid),
		.cfg(cfg), .cfgLoad(cfgLoad), .srReq(srReq), .pdReq(pdReq), .inSelfRefresh(inSelfRefresh),
		.inPowerDown(inPowerDown), .pins(pins), .dqOut(dqOut), .dqOe(dqOe), .dqIn(dqIn));
	hsd_sdram_model mem0 (.clk(clk), .pins(pins), .dqOut(dqOut), .dqIn(dqIn), .violCnt(violCnt));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// watches the command pins for refreshes and auto precharge flags
	always @(posedge clk) if (pins.cke && !pins.csN) begin
		if (pins.cmd == CMD_READ || pins.cmd == CMD_WRITE) accA10 <= pins.addr[ADDR_AP_BIT];
		if (pins.cmd == CMD_REF) refCnt <= refCnt + 1;
	end

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	function automatic logic [31:0] wd(input logic [7:0] c, input int i);
		return {16'h5a3c, c, 8'(i)};
	endfunction : wd

	task automatic chk(input logic [31:0] gotV, input logic [31:0] exp, input string what);
		nChecks++;
		if (gotV !== exp) begin
			errorCnt++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, gotV, exp);
		end
	endtask : chk

	task automatic close_out();
		$display("errors %0d checks %0d", errorCnt, nChecks);
		if (errorCnt == 0 && nChecks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out

	// one access: holds the request until taken, feeds and collects beats
	task automatic acc(input logic w, input logic ap, input logic [1:0] b, input logic [11:0] r, input logic [7:0] c,
		input int n);
		got = 0;
		rdQ.delete();
		req = '{write: w, autoPre: ap, bank: b, row: r, col: c};
		wrData = wd(c, 0);
		reqValid = 1'b1;
		for (k = 0; k < 400 && got < n; k++) begin
			@(negedge clk);
			if (reqReady) reqValid = 1'b0;
			if (wrTake) begin
				chk(dqOe, 1'b1, "write beat driven");
				got++;
				wrData = wd(c, got);
			end
			if (rdValid) begin
				rdQ.push_back(rdData);
				got++;
			end
		end
		reqValid = 1'b0;
		repeat (12) begin
			@(negedge clk);
			if (wrTake || rdValid) got++;
		end
	endtask : acc

	task automatic set_cfg(input logic [2:0] bl, input logic wbm, input logic [2:0] cl);
		cfg = '{burstLen: bl, writeBurstModeBit: wbm, casLat: cl};
		cfgLoad = 1'b1;
		@(negedge clk);
		cfgLoad = 1'b0;
		repeat (20) @(negedge clk);
	endtask : set_cfg

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_burst();
		acc(1'b1, 1'b1, 2'h1, 12'h0a5, 8'h08, 4);
		chk(got, 4, "write beats");
		chk(accA10, 1'b1, "auto precharge flag");
		acc(1'b0, 1'b1, 2'h1, 12'h0a5, 8'h08, 4);
		for (int i = 0; i < 4; i++) chk(rdQ[i], wd(8'h08, i), "read back");
	endtask : t_burst

	task automatic t_single();
		// burst of eight at latency three, then row misses both ways on one bank
		set_cfg(3'h3, 1'b1, 3'h3);
		acc(1'b1, 1'b0, 2'h2, 12'h0a5, 8'h05, 1);
		chk(got, 1, "single write beats");
		acc(1'b0, 1'b0, 2'h2, 12'h0a5, 8'h05, 8);
		chk(got, 8, "read beats in single write mode");
		chk(rdQ[0], wd(8'h05, 0), "single write data");
		acc(1'b1, 1'b0, 2'h2, 12'h0b6, 8'h06, 1);
		chk(got, 1, "single write to other row");
		acc(1'b0, 1'b0, 2'h2, 12'h0a5, 8'h04, 8);
		chk(rdQ[1], wd(8'h05, 0), "reopened row data");
	endtask : t_single

	task automatic t_page();
		set_cfg(BL_PAGE, 1'b0, 3'h2);
		acc(1'b0, 1'b1, 2'h3, 12'h0a5, 8'h00, PAGE_BEATS);
		chk(got, PAGE_BEATS, "page beats");
		chk(accA10, 1'b0, "no auto precharge on page");
		set_cfg(3'h2, 1'b0, 3'h2);
	endtask : t_page

	task automatic t_power();
		r0 = refCnt;
		repeat (400) @(negedge clk);
		chk(refCnt > r0, 1'b1, "distributed refresh");
		srReq = 1'b1;
		for (k = 0; k < 60 && !inSelfRefresh; k++) @(negedge clk);
		chk(pins.cke, 1'b0, "self refresh clock enable");
		chk(inSelfRefresh, 1'b1, "self refresh entered");
		repeat (10) @(negedge clk);
		chk(pins.cke, 1'b0, "self refresh held");
		srReq = 1'b0;
		repeat (20) @(negedge clk);
		chk(pins.cke, 1'b1, "self refresh left");
		chk(inSelfRefresh, 1'b0, "self refresh status cleared");
		pdReq = 1'b1;
		for (k = 0; k < 60 && !inPowerDown; k++) @(negedge clk);
		chk(pins.cke, 1'b0, "power-down clock enable");
		for (k = 0; k < 60 && inPowerDown; k++) @(negedge clk);
		chk(inPowerDown, 1'b0, "power-down bounded");
		pdReq = 1'b0;
		repeat (20) @(negedge clk);
	endtask : t_power

	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		rst_n = 1'b0;
		reqValid = 1'b0;
		req = '0;
		wrData = 32'h0;
		cfg = CFG_RESET;
		cfgLoad = 1'b0;
		srReq = 1'b0;
		pdReq = 1'b0;
		errorCnt = 0;
		nChecks = 0;
		repeat (20) @(negedge clk);
		chk(pins, PINS_RESET, "reset pins");
		chk(dqOe, 1'b0, "reset drive");
		rst_n = 1'b1;
		repeat (5) @(negedge clk);
		t_burst();
		t_single();
		t_page();
		t_power();
		chk(violCnt, 0, "device timing faults");
		close_out();
	end

	initial begin
		#(40 * 5000);
		errorCnt++;
		close_out();
	end

endmodule : hsd_ctrl_tb
